/* dedicated_reg_cfg.svh */
// Constants of the dedicated register bank: locations, addresses, resets.
// Assumes inclusion by bare name from the bank's files.
`ifndef DEDICATED_REG_CFG_SVH
`define DEDICATED_REG_CFG_SVH
// Register-file locations
`define RF_LOC_B 6'h0A
`define RF_LOC_ACC 6'h0B
`define RF_LOC_DPX 6'h38
`define RF_LOC_SPX 6'h3C
// Special-function addresses
`define SFR_ADDR_SP 9'h081
`define SFR_ADDR_DPL 9'h082
`define SFR_ADDR_DPH 9'h083
`define SFR_ADDR_DATA_REGION_SELECT 9'h084
`define SFR_ADDR_SPH 9'h0BE
`define SFR_ADDR_PSW 9'h0D0
`define SFR_ADDR_PROGRAM_STATUS_WORD_EXT 9'h0D1
`define SFR_ADDR_ACC 9'h0E0
`define SFR_ADDR_B 9'h0F0
// Storage entries; dwords are four consecutive entries, lowest location first
`define DREG_COUNT 12
`define IDX_LOC56 4'h0
`define IDX_DATA_REGION_SELECT 4'h1
`define IDX_DPH 4'h2
`define IDX_DPL 4'h3
`define IDX_LOC60 4'h4
`define IDX_LOC61 4'h5
`define IDX_SPH 4'h6
`define IDX_SP 4'h7
`define IDX_ACC 4'h8
`define IDX_B 4'h9
`define IDX_PSW 4'hA
`define IDX_PROGRAM_STATUS_WORD_EXT 4'hB
// Reset values
`define RST_SP 8'h07
`define RST_DATA_REGION_SELECT 8'h01
`define RST_OTHER 8'h00
// Hardware status bits derived from the primary operand byte
`define PSW_PARITY_BIT 0
`define PROGRAM_STATUS_WORD_EXT_ZERO_BIT 1
`define PROGRAM_STATUS_WORD_EXT_NEG_BIT 5
// Read data for unowned special-function locations; value is not promised
`define SFR_UNDEF_DATA 8'h00
`endif

/* dedicated_reg_pkg.sv */
// Types shared by the dedicated register bank.
// Assumes nothing of its surroundings.
package dedicated_reg_pkg;
   typedef enum logic [1:0] {size_byte, size_word, size_dword} access_size_t;
endpackage : dedicated_reg_pkg

/* dedicated_register_sfr_alias.sv */
// Dedicated core registers with register-file and special-function views.
// Assumes the execution logic drives both request ports synchronously to ref_clk.
//
// Summary of operation
// - Primary operand byte is register location 11 and special address E0.
// - Multiply auxiliary byte is register location 10 and special address F0.
// - Register-file view answers one cycle sooner than the special view.
// - Status flags in both status words follow only the primary operand byte.
// - Extended data pointer is dword 56; bytes 57..59 alias addresses 84,83,82.
// - Data pointer word is high byte over low byte.
// - Region select byte gives the external data move region.
// - Region select resets to 01; other data pointer bytes reset to zero.
// - Extended stack pointer is dword 60; 63 low byte, 62 high byte.
// - Stack low byte aliases address 81, stack high byte address BE.
// - Writes to unowned special addresses complete but change nothing.
// - Reads of unowned special addresses return an unpromised value.
// - Addresses below 80 and from 100 up are never owned.
// - Special accesses are single bytes only; wider ones are refused.
// - Stack low resets to 07 and region select to 01; the remaining bytes reset to zero.
// - Dword bytes reach the register file only through dword access.
`timescale 1ns/100ps
`include "dedicated_reg_cfg.svh"
module dedicated_register_sfr_alias (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rf_req,
   input wire logic rf_we,
   input wire dedicated_reg_pkg::access_size_t rf_size,
   input wire logic [5:0] rf_loc,
   input wire logic [31:0] rf_wdata,
   output logic rf_ack,
   output logic rf_miss,
   output logic [31:0] rf_rdata,
   input wire logic sfr_req,
   input wire logic sfr_we,
   input wire dedicated_reg_pkg::access_size_t sfr_size,
   input wire logic [8:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic sfr_ack,
   output logic sfr_hit,
   output logic [7:0] sfr_rdata,
   output logic [7:0] primary_operand_byte,
   output logic [7:0] program_status_word,
   output logic [7:0] program_status_word_ext,
   output logic [15:0] data_pointer_word,
   output logic [7:0] data_region_select,
   output logic [15:0] stack_pointer
);
   import dedicated_reg_pkg::*;

   logic [7:0] store [0:`DREG_COUNT-1];
   logic [7:0] raw_next [0:`DREG_COUNT-1];
   logic [7:0] next_store [0:`DREG_COUNT-1];
   logic [`DREG_COUNT-1:0] wr_any;
   logic rf_ok;
   logic rf_dword;
   logic [3:0] rf_base;
   logic rf_take_wr;
   logic dec_ok;
   logic [3:0] dec_idx;
   logic s_valid;
   logic s_we;
   logic s_ok;
   logic [3:0] s_idx;
   logic [7:0] s_wdata;
   logic sfr_do_wr;
   logic acc_wr;

   // ********************************************************************
   // Register-file view decode
   // ********************************************************************
   // Trade-off: a refused register access still answers, with miss set, so
   // the requester never waits on a location that does not exist.
   always_comb begin
      rf_ok = 1'b0;
      rf_dword = 1'b0;
      rf_base = `IDX_LOC56;
      if (rf_size == size_byte && rf_loc == `RF_LOC_ACC) begin
         rf_ok = 1'b1;
         rf_base = `IDX_ACC;
      end else if (rf_size == size_byte && rf_loc == `RF_LOC_B) begin
         rf_ok = 1'b1;
         rf_base = `IDX_B;
      end else if (rf_size == size_dword && rf_loc == `RF_LOC_DPX) begin
         rf_ok = 1'b1;
         rf_dword = 1'b1;
         rf_base = `IDX_LOC56;
      end else if (rf_size == size_dword && rf_loc == `RF_LOC_SPX) begin
         rf_ok = 1'b1;
         rf_dword = 1'b1;
         rf_base = `IDX_LOC60;
      end
      // Byte or word access into 56..63 falls through as a miss
   end

   assign rf_take_wr = rf_req & rf_we & rf_ok;

   // ********************************************************************
   // Special-function view decode
   // ********************************************************************
   // Only this bank's locations hit; everything else, including peripheral
   // addresses, is unowned here.
   always_comb begin
      dec_ok = 1'b1;
      dec_idx = `IDX_ACC;
      case (sfr_addr)
         `SFR_ADDR_SP: dec_idx = `IDX_SP;
         `SFR_ADDR_SPH: dec_idx = `IDX_SPH;
         `SFR_ADDR_DPL: dec_idx = `IDX_DPL;
         `SFR_ADDR_DPH: dec_idx = `IDX_DPH;
         `SFR_ADDR_DATA_REGION_SELECT: dec_idx = `IDX_DATA_REGION_SELECT;
         `SFR_ADDR_PSW: dec_idx = `IDX_PSW;
         `SFR_ADDR_PROGRAM_STATUS_WORD_EXT: dec_idx = `IDX_PROGRAM_STATUS_WORD_EXT;
         `SFR_ADDR_ACC: dec_idx = `IDX_ACC;
         `SFR_ADDR_B: dec_idx = `IDX_B;
         default: dec_ok = 1'b0;
      endcase
   end

   // Extra stage makes the special view one cycle slower
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_valid <= 1'b0;
         s_we <= 1'b0;
         s_ok <= 1'b0;
         s_idx <= `IDX_ACC;
         s_wdata <= 8'h00;
      end else begin
         s_valid <= sfr_req;
         s_we <= sfr_we;
         s_ok <= dec_ok & (sfr_size == size_byte);
         s_idx <= dec_idx;
         s_wdata <= sfr_wdata;
      end
   end

   assign sfr_do_wr = s_valid & s_we & s_ok;

   // ********************************************************************
   // Shared storage
   // ********************************************************************
   // One flop per byte serves both views
   for (genvar i = 0; i < `DREG_COUNT; i++) begin : g_entry
      logic [3:0] off;
      logic rf_wr;
      logic sfr_wr;
      logic [7:0] rf_byte;
      assign off = 4'(i) - rf_base;
      assign rf_wr = rf_take_wr & (rf_dword ? (off < 4'h4) : (off == 4'h0));
      assign rf_byte = rf_dword ? rf_wdata[{~off[1:0], 3'b000} +: 8] : rf_wdata[7:0];
      assign sfr_wr = sfr_do_wr & (s_idx == 4'(i));
      assign wr_any[i] = rf_wr | sfr_wr;
      // Colliding writes: the older special-view write lands last and wins
      always_comb begin
         raw_next[i] = store[i];
         if (rf_wr) begin
            raw_next[i] = rf_byte;
         end
         if (sfr_wr) begin
            raw_next[i] = s_wdata;
         end
      end
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            if (4'(i) == `IDX_SP) begin
               store[i] <= `RST_SP;
            end else if (4'(i) == `IDX_DATA_REGION_SELECT) begin
               store[i] <= `RST_DATA_REGION_SELECT;
            end else begin
               store[i] <= `RST_OTHER;
            end
         end else begin
            store[i] <= next_store[i];
         end
      end
   end

   assign acc_wr = wr_any[`IDX_ACC];

   // Hardware status bits refresh only when the primary operand byte is
   // written; software writes to those bit positions are dropped.
   always_comb begin
      next_store = raw_next;
      next_store[`IDX_PSW][`PSW_PARITY_BIT] = acc_wr ? ^raw_next[`IDX_ACC]
         : store[`IDX_PSW][`PSW_PARITY_BIT];
      next_store[`IDX_PROGRAM_STATUS_WORD_EXT][`PROGRAM_STATUS_WORD_EXT_ZERO_BIT] = acc_wr ? (raw_next[`IDX_ACC] == 8'h00)
         : store[`IDX_PROGRAM_STATUS_WORD_EXT][`PROGRAM_STATUS_WORD_EXT_ZERO_BIT];
      next_store[`IDX_PROGRAM_STATUS_WORD_EXT][`PROGRAM_STATUS_WORD_EXT_NEG_BIT] = acc_wr ? raw_next[`IDX_ACC][7]
         : store[`IDX_PROGRAM_STATUS_WORD_EXT][`PROGRAM_STATUS_WORD_EXT_NEG_BIT];
   end

   // ********************************************************************
   // Answers
   // ********************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rf_ack <= 1'b0;
         rf_miss <= 1'b0;
         rf_rdata <= 32'h0000_0000;
      end else begin
         rf_ack <= rf_req;
         rf_miss <= rf_req & ~rf_ok;
         if (rf_req && rf_ok && rf_dword) begin
            rf_rdata <= {store[rf_base], store[4'(rf_base + 4'h1)],
               store[4'(rf_base + 4'h2)], store[4'(rf_base + 4'h3)]};
         end else if (rf_req && rf_ok) begin
            rf_rdata <= {24'h00_0000, store[rf_base]};
         end else if (rf_req) begin
            rf_rdata <= 32'h0000_0000;
         end
      end
   end

   // Refused special accesses answer too; the read value is a fixed filler
   // that callers must not rely on
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sfr_ack <= 1'b0;
         sfr_hit <= 1'b0;
         sfr_rdata <= 8'h00;
      end else begin
         sfr_ack <= s_valid;
         sfr_hit <= s_valid & s_ok;
         if (s_valid) begin
            sfr_rdata <= s_ok ? store[s_idx] : `SFR_UNDEF_DATA;
         end
      end
   end

   // Mirrors taken straight from the storage flops
   assign primary_operand_byte = store[`IDX_ACC];
   assign program_status_word = store[`IDX_PSW];
   assign program_status_word_ext = store[`IDX_PROGRAM_STATUS_WORD_EXT];
   assign data_pointer_word = {store[`IDX_DPH], store[`IDX_DPL]};
   assign data_region_select = store[`IDX_DATA_REGION_SELECT];
   assign stack_pointer = {store[`IDX_SPH], store[`IDX_SP]};

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   acc_alias_a: assert property (
      sfr_req && sfr_we && sfr_size == size_byte && sfr_addr == `SFR_ADDR_ACC
      |-> ##2 primary_operand_byte == $past(sfr_wdata, 2))
      else $error("special write did not reach primary operand byte");

   aux_alias_a: assert property (
      rf_req && rf_we && rf_size == size_byte && rf_loc == `RF_LOC_B && !sfr_do_wr
      |=> store[`IDX_B] == $past(rf_wdata[7:0]))
      else $error("register write did not reach auxiliary byte");

   rf_latency_a: assert property (
      rf_req |=> rf_ack ##1 (rf_ack == $past(rf_req, 1)))
      else $error("register view answer not one cycle after request");

   sfr_latency_a: assert property (
      sfr_req && !s_valid |-> ##1 !sfr_ack ##1 sfr_ack)
      else $error("special view answer not two cycles after request");

   flag_source_a: assert property (
      !$stable(store[`IDX_PSW][`PSW_PARITY_BIT]) || !$stable(store[`IDX_PROGRAM_STATUS_WORD_EXT][`PROGRAM_STATUS_WORD_EXT_ZERO_BIT])
      |-> $past(acc_wr))
      else $error("status flag changed without operand byte write");

   dpx_dword_a: assert property (
      rf_req && rf_we && rf_size == size_dword && rf_loc == `RF_LOC_DPX && !sfr_do_wr
      |=> data_region_select == $past(rf_wdata[23:16])
      && data_pointer_word == $past(rf_wdata[15:0]))
      else $error("data pointer dword write misplaced");

   spx_dword_a: assert property (
      rf_req && rf_we && rf_size == size_dword && rf_loc == `RF_LOC_SPX && !sfr_do_wr
      |=> stack_pointer == $past(rf_wdata[15:0]))
      else $error("stack pointer dword write misplaced");

   reset_value_a: assert property (
      $rose(rst_n) |-> stack_pointer == {`RST_OTHER, `RST_SP}
      && data_region_select == `RST_DATA_REGION_SELECT && data_pointer_word == 16'h0000
      && primary_operand_byte == `RST_OTHER && program_status_word == `RST_OTHER)
      else $error("wrong value after reset");

   unowned_write_a: assert property (
      s_valid && s_we && !s_ok && !rf_take_wr
      |=> $stable(primary_operand_byte) && $stable(stack_pointer)
      && $stable(data_pointer_word))
      else $error("refused special write changed storage");

   low_space_a: assert property (
      sfr_req && (sfr_addr < 9'h080 || sfr_addr > 9'h0FF) |-> ##2 sfr_ack && !sfr_hit)
      else $error("unowned special address reported as hit");

   byte_only_a: assert property (
      sfr_req && sfr_size != size_byte |-> ##2 !sfr_hit)
      else $error("wide special access accepted");

   dword_only_a: assert property (
      rf_req && rf_size != size_dword && rf_loc >= `RF_LOC_DPX |=> rf_miss)
      else $error("non-dword access to dword locations accepted");

   cross_view_a: assert property (
      (rf_take_wr && rf_dword && rf_base == `IDX_LOC60 && !sfr_do_wr)
      ##1 (!rf_take_wr && !sfr_do_wr)
      ##1 (sfr_req && !sfr_we && sfr_size == size_byte && sfr_addr == `SFR_ADDR_SP
      && !sfr_do_wr && !rf_take_wr) |-> ##2 sfr_rdata == $past(rf_wdata[7:0], 4))
      else $error("special read missed register write");

   no_alias_a: assert property (
      dec_ok |-> dec_idx != `IDX_LOC56 && dec_idx != `IDX_LOC60 && dec_idx != `IDX_LOC61)
      else $error("special decode selected unaliased location");

   status_value_a: assert property (
      acc_wr |=> program_status_word[`PSW_PARITY_BIT] == ^primary_operand_byte
      && program_status_word_ext[`PROGRAM_STATUS_WORD_EXT_ZERO_BIT] == (primary_operand_byte == 8'h00)
      && program_status_word_ext[`PROGRAM_STATUS_WORD_EXT_NEG_BIT] == primary_operand_byte[7])
      else $error("status bits do not match operand byte");

   refused_file_a: assert property (
      rf_req && rf_we && rf_size != size_dword && rf_loc >= `RF_LOC_DPX && !sfr_do_wr
      |=> $stable(data_pointer_word) && $stable(stack_pointer) && $stable(data_region_select))
      else $error("refused register write changed dword storage");

   hit_with_ack_a: assert property (
      sfr_hit |-> sfr_ack)
      else $error("special hit without answer");

   miss_with_ack_a: assert property (
      rf_miss |-> rf_ack)
      else $error("register miss without answer");

   // ********************************************************************
   // Cover points
   // ********************************************************************
   // Main traffic shapes; the cross-view case is the one most easily lost
   cover_sfr_write_c: cover property (sfr_req && sfr_we && dec_ok ##2 sfr_hit);
   cover_rf_dword_c: cover property (rf_take_wr && rf_dword ##1 rf_ack && !rf_miss);
   cover_collision_c: cover property (sfr_do_wr && rf_take_wr);
   cover_unowned_c: cover property (sfr_req && !dec_ok ##2 sfr_ack && !sfr_hit);
   cover_cross_view_c: cover property (rf_take_wr && rf_dword ##2 sfr_req && !sfr_we);

endmodule : dedicated_register_sfr_alias

/* cpu_exec_model.sv */
// Execution-side request model that drives both views of the dedicated register bank.
// Assumes ref_clk is the bank clock; the bench calls the two tasks hierarchically.
`timescale 1ns/100ps
module cpu_exec_model (
   input wire logic ref_clk,
   output logic rf_req,
   output logic rf_we,
   output dedicated_reg_pkg::access_size_t rf_size,
   output logic [5:0] rf_loc,
   output logic [31:0] rf_wdata,
   input wire logic rf_ack,
   input wire logic rf_miss,
   input wire logic [31:0] rf_rdata,
   output logic sfr_req,
   output logic sfr_we,
   output dedicated_reg_pkg::access_size_t sfr_size,
   output logic [8:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   input wire logic sfr_ack,
   input wire logic sfr_hit,
   input wire logic [7:0] sfr_rdata
);
   import dedicated_reg_pkg::*;
   // ********************
   // Idle levels
   // ********************
   initial begin
      rf_req = 1'b0;
      rf_we = 1'b0;
      rf_size = size_byte;
      rf_loc = 6'h00;
      rf_wdata = 32'h0;
      sfr_req = 1'b0;
      sfr_we = 1'b0;
      sfr_size = size_byte;
      sfr_addr = 9'h000;
      sfr_wdata = 8'h00;
   end
   // ********************
   // Requests
   // ********************
   // One-cycle request; released data is inverted so stale values never look valid
   task automatic file_xfer(input logic we, input access_size_t sz, input logic [5:0] loc,
      input logic [31:0] wd, output logic miss, output logic [31:0] rd, output int lat);
      @(negedge ref_clk);
      rf_req = 1'b1;
      rf_we = we;
      rf_size = sz;
      rf_loc = loc;
      rf_wdata = wd;
      @(negedge ref_clk);
      rf_req = 1'b0;
      rf_wdata = ~wd;
      rf_loc = ~loc;
      lat = 1;
      while (rf_ack !== 1'b1 && lat < 5) begin
         @(negedge ref_clk);
         lat++;
      end
      miss = rf_miss;
      rd = rf_rdata;
   endtask : file_xfer
   // Wider sizes are only issued when a scenario asks for a refusal
   task automatic spec_xfer(input logic we, input access_size_t sz, input logic [8:0] a,
      input logic [7:0] wd, output logic hit, output logic [7:0] rd, output int lat);
      @(negedge ref_clk);
      sfr_req = 1'b1;
      sfr_we = we;
      sfr_size = sz;
      sfr_addr = a;
      sfr_wdata = wd;
      @(negedge ref_clk);
      sfr_req = 1'b0;
      sfr_wdata = ~wd;
      sfr_addr = ~a;
      lat = 1;
      while (sfr_ack !== 1'b1 && lat < 5) begin
         @(negedge ref_clk);
         lat++;
      end
      hit = sfr_hit;
      rd = sfr_rdata;
   endtask : spec_xfer
endmodule : cpu_exec_model

/* dedicated_register_sfr_alias_tb.sv */
// Self-checking bench for the dedicated register bank, both access views.
// Assumes cpu_exec_model drives the request ports on falling edges.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("[FAIL] %s expected %h seen %h", what, exp, got); \
      end \
   end
module dedicated_register_sfr_alias_tb;
   import dedicated_reg_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rf_req, rf_we, rf_ack, rf_miss, sfr_req, sfr_we, sfr_ack, sfr_hit, h, m;
   access_size_t rf_size, sfr_size;
   logic [5:0] rf_loc;
   logic [31:0] rf_wdata, rf_rdata, rd;
   logic [8:0] sfr_addr;
   logic [7:0] sfr_wdata, sfr_rdata, sd, primary_operand_byte, program_status_word;
   logic [7:0] program_status_word_ext, data_region_select;
   logic [15:0] data_pointer_word, stack_pointer;
   int fail_count = 0;
   int compares = 0;
   int lat;
   logic [8:0] own_a [9] = '{9'h081, 9'h082, 9'h083, 9'h084, 9'h0BE, 9'h0D0, 9'h0D1,
      9'h0E0, 9'h0F0};
   logic [7:0] rst_v [9] = '{8'h07, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [8:0] bad_a [7] = '{9'h000, 9'h07F, 9'h080, 9'h085, 9'h0BF, 9'h100, 9'h1FF};
   access_size_t bad_sz [6] = '{size_byte, size_byte, size_word, size_word, size_dword,
      size_dword};
   logic [5:0] bad_loc [6] = '{6'd57, 6'd12, 6'd56, 6'd10, 6'd57, 6'd11};
   always #5 ref_clk = ~ref_clk;
   dedicated_register_sfr_alias i_dut (.ref_clk, .rst_n, .rf_req, .rf_we, .rf_size, .rf_loc,
      .rf_wdata, .rf_ack, .rf_miss, .rf_rdata, .sfr_req, .sfr_we, .sfr_size, .sfr_addr,
      .sfr_wdata, .sfr_ack, .sfr_hit, .sfr_rdata, .primary_operand_byte,
      .program_status_word, .program_status_word_ext, .data_pointer_word,
      .data_region_select, .stack_pointer);
   cpu_exec_model i_cpu (.ref_clk, .rf_req, .rf_we, .rf_size, .rf_loc, .rf_wdata, .rf_ack,
      .rf_miss, .rf_rdata, .sfr_req, .sfr_we, .sfr_size, .sfr_addr, .sfr_wdata, .sfr_ack,
      .sfr_hit, .sfr_rdata);
   // ********************
   // Shared tasks
   // ********************
   task automatic end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic do_reset;
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      `CHK("stack", 16'h0007, stack_pointer)
      `CHK("region", 8'h01, data_region_select)
      `CHK("data_pointer_word", 16'h0000, data_pointer_word)
      `CHK("operand", 8'h00, primary_operand_byte)
      `CHK("status", 8'h00, program_status_word)
      `CHK("status_ext", 8'h00, program_status_word_ext)
   endtask : do_reset
   task automatic spec_wr(input logic [8:0] a, input logic [7:0] d, input logic eh,
      input access_size_t sz = size_byte);
      i_cpu.spec_xfer(1'b1, sz, a, d, h, sd, lat);
      `CHK("spec hit", eh, h)
      `CHK("spec latency", 2, lat)
   endtask : spec_wr
   task automatic spec_rd(input logic [8:0] a, input logic [7:0] e);
      i_cpu.spec_xfer(1'b0, size_byte, a, 8'h00, h, sd, lat);
      `CHK("spec hit", 1'b1, h)
      `CHK("spec data", e, sd)
      `CHK("spec latency", 2, lat)
   endtask : spec_rd
   task automatic file_wr(input access_size_t sz, input logic [5:0] loc, input logic [31:0] d,
      input logic em);
      i_cpu.file_xfer(1'b1, sz, loc, d, m, rd, lat);
      `CHK("file miss", em, m)
   endtask : file_wr
   task automatic file_rd(input access_size_t sz, input logic [5:0] loc, input logic [31:0] e);
      i_cpu.file_xfer(1'b0, sz, loc, 32'h0, m, rd, lat);
      `CHK("file miss", 1'b0, m)
      `CHK("file data", e, rd)
      `CHK("file latency", 1, lat)
   endtask : file_rd
   // ********************
   // Scenarios
   // ********************
   initial begin
      do_reset();
      for (int i = 0; i < 9; i++) spec_rd(own_a[i], rst_v[i]);
      file_rd(size_dword, 6'd60, 32'h0000_0007);
      file_rd(size_dword, 6'd56, 32'h0001_0000);
      spec_wr(9'h0E0, 8'h5A, 1'b1);
      file_rd(size_byte, 6'd11, 32'h0000_005A);
      spec_wr(9'h0F0, 8'hA5, 1'b1);
      file_rd(size_byte, 6'd10, 32'h0000_00A5);
      spec_wr(9'h084, 8'h3C, 1'b1);
      spec_wr(9'h083, 8'h12, 1'b1);
      spec_wr(9'h082, 8'h34, 1'b1);
      file_rd(size_dword, 6'd56, 32'h003C_1234);
      `CHK("data_pointer_word", 16'h1234, data_pointer_word)
      `CHK("region", 8'h3C, data_region_select)
      spec_wr(9'h081, 8'h99, 1'b1);
      spec_wr(9'h0BE, 8'h88, 1'b1);
      file_rd(size_dword, 6'd60, 32'h0000_8899);
      `CHK("stack", 16'h8899, stack_pointer)
      file_wr(size_dword, 6'd56, 32'hC3A1_B2D4, 1'b0);
      spec_rd(9'h084, 8'hA1);
      spec_rd(9'h083, 8'hB2);
      spec_rd(9'h082, 8'hD4);
      // Stack low read follows the dword write after one idle cycle
      file_wr(size_dword, 6'd60, 32'hE7F6_0102, 1'b0);
      spec_rd(9'h081, 8'h02);
      spec_rd(9'h0BE, 8'h01);
      // Status bits must follow the operand byte only
      file_wr(size_byte, 6'd11, 32'h0000_0080, 1'b0);
      spec_rd(9'h0E0, 8'h80);
      `CHK("parity", 1'b1, program_status_word[0])
      `CHK("negative", 1'b1, program_status_word_ext[5])
      `CHK("zero", 1'b0, program_status_word_ext[1])
      spec_wr(9'h0E0, 8'h00, 1'b1);
      file_wr(size_byte, 6'd10, 32'h0000_00FF, 1'b0);
      `CHK("parity", 1'b0, program_status_word[0])
      `CHK("negative", 1'b0, program_status_word_ext[5])
      `CHK("zero", 1'b1, program_status_word_ext[1])
      for (int i = 0; i < 6; i++) file_wr(bad_sz[i], bad_loc[i], 32'hFFFF_FFFF, 1'b1);
      for (int i = 0; i < 7; i++) spec_wr(bad_a[i], 8'hFF, 1'b0);
      // Unowned read: only completion is promised, never the value
      i_cpu.spec_xfer(1'b0, size_byte, 9'h085, 8'h00, h, sd, lat);
      `CHK("unowned hit", 1'b0, h)
      `CHK("unowned latency", 2, lat)
      spec_wr(9'h0E0, 8'h77, 1'b0, size_word);
      spec_wr(9'h0E0, 8'h77, 1'b0, size_dword);
      `CHK("operand", 8'h00, primary_operand_byte)
      file_rd(size_dword, 6'd56, 32'hC3A1_B2D4);
      file_rd(size_dword, 6'd60, 32'hE7F6_0102);
      file_rd(size_byte, 6'd10, 32'h0000_00FF);
      do_reset();
      file_rd(size_dword, 6'd56, 32'h0001_0000);
      end_of_test();
   end
   // Far beyond the fewer than two hundred cycles the scenarios need
   initial begin
      #50000;
      fail_count++;
      end_of_test();
   end
endmodule : dedicated_register_sfr_alias_tb
